// *** logic/lcm_logic_cell.sv ***
// Module: one programmable logic cell with APB configuration
//
// Functional notes
// - Four operating modes: normal, arithmetic, up/down counter, clearable counter.
// - Seven inputs steered per mode; clock, clear, preset controls separate.
// - Register has synchronous clock enable from data_in_1 in every mode.
// - Normal mode four-input function; carry-in or data_in_3 selected as one input.
// - Normal mode function combines with cascade-in; register or function drives outputs.
// - Packing: data_in_4 feeds register; outputs carry register and function either way.
// - Packed register keeps clock enable, clear and preset.
// - Packed register with cascade is refused by configuration logic.
// - Arithmetic: two three-input functions give result and carry-out; cascade allowed.
// - Up/down counter: enable, direction, two-way load multiplexer, count and carry functions.
// - Counter modes also load asynchronously via clear and preset paths.
// - Clearable counter: sync clear replaces cascade-in, ANDed after load multiplexer.
// - Emulated bus: several enables give low, none gives high.
// - data_in_3, cluster_ctrl_a, cluster_ctrl_b drive clear/preset/load; either line clears.
// - Load configurations: cluster_ctrl_a copies data_in_3 via preset and clear paths.
// - Clear and preset active low; unused ones held high.
// - Six clear/preset configurations.
// - Enabled chip-wide reset overrides all; inverted registers may read set.
// - Preset realised by loading a one, or by clear with inversion.
// - Clear-and-preset: cluster_ctrl_a presets, cluster_ctrl_b clears.
// - Load-with-clear: cluster_ctrl_a loads, cluster_ctrl_b clears only.
// - Load-with-preset: register inverted, cluster_ctrl_b sets, data_in_3 inverted.
module lcm_logic_cell
    import lcm_pkg::*;
#(
    parameter int TRI_SRC = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data_in_1,
    input  wire logic        data_in_2,
    input  wire logic        data_in_3,
    input  wire logic        data_in_4,
    input  wire logic        carry_in,
    input  wire logic        cascade_in,
    input  wire logic        cluster_ctrl_a,
    input  wire logic        cluster_ctrl_b,
    input  wire logic        chip_reset_n,
    output logic             local_out,
    output logic             global_out,
    output logic             carry_out,
    output logic             cascade_out,
    output logic             tri_bus_out
);

    localparam int TRI_W = 2 * TRI_SRC;

    // Whole state of the cell
    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [CFG_W-1:0] cfg;
        logic [LUT_W-1:0] lut;
        logic [TRI_W-1:0] tri_src;
        logic             cell_q;
        logic             cfg_reject;
        logic             local_out;
        logic             global_out;
        logic             carry_out;
        logic             cascade_out;
        logic             lut_out;
        logic             tri_out;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } lcm_state_t;

    localparam lcm_state_t ST_RESET = '{
        pin_s1: PIN_SYNC_RESET, pin_s2: PIN_SYNC_RESET, cfg: CFG_RESET,
        lut: LUT_RESET, tri_out: 1'b1, default: '0
    };

    lcm_state_t       st;
    lcm_state_t       next_st;
    lcm_op_t          op;
    lcm_cp_t          cp;
    logic             s_d1;
    logic             s_d2;
    logic             s_d3;
    logic             s_d4;
    logic             s_cin;
    logic             s_casc;
    logic             s_ca;
    logic             s_cb;
    logic             s_chiprst_n;
    logic             inv;
    logic             q_obs;
    logic [3:0]       idx4;
    logic [2:0]       idx3;
    logic             lut_norm;
    logic             lut_data;
    logic             lut_carry;
    logic             comb_res;
    logic             carry_res;
    logic             d_sync;
    logic             ctrl_clr;
    logic             clr_n;
    logic             pre_n;
    logic             chip_act;
    logic             ce;
    logic [TRI_W/2-1:0] tri_oe;
    logic [TRI_W/2-1:0] tri_dat;
    logic [31:0]      stat_word;
    logic [CFG_W-1:0] wcfg;
    logic             wcfg_bad;
    logic             setup_ph;
    logic             access_ph;

    // Next-state logic of the whole cell
    always_comb begin
        next_st = st;
        // Two-stage synchronisers on every pin input
        next_st.pin_s1 = {chip_reset_n, cluster_ctrl_b, cluster_ctrl_a, cascade_in,
                          carry_in, data_in_4, data_in_3, data_in_2, data_in_1};
        next_st.pin_s2 = st.pin_s1;
        s_d1        = st.pin_s2[PIN_D1];
        s_d2        = st.pin_s2[PIN_D2];
        s_d3        = st.pin_s2[PIN_D3];
        s_d4        = st.pin_s2[PIN_D4];
        s_cin       = st.pin_s2[PIN_CIN];
        s_casc      = st.pin_s2[PIN_CASC];
        s_ca        = st.pin_s2[PIN_CA];
        s_cb        = st.pin_s2[PIN_CB];
        s_chiprst_n = st.pin_s2[PIN_CHIPRST];
        op = lcm_op_t'(st.cfg[CFG_OP_LSB +: OP_W]);
        cp = lcm_cp_t'(st.cfg[CFG_CP_LSB +: CP_W]);

        // Stored bit is inverted in load-with-preset
        inv   = (cp == CP_LOAD_PRE);
        q_obs = st.cell_q ^ inv;

        // Function inputs: four-input table or two three-input tables
        idx4 = {s_d4, (st.cfg[CFG_CARRY_SEL] ? s_cin : s_d3), s_d2, s_d1};
        if (op == OP_ARITH) begin
            idx3 = {s_cin, s_d2, s_d1};
        end else begin
            idx3 = {s_cin, s_d3, q_obs};
        end
        lut_norm  = st.lut[idx4];
        lut_data  = st.lut[{1'b0, idx3}];
        lut_carry = st.lut[{1'b1, idx3}];

        // Mode-dependent routing of the seven cell inputs
        case (op)
            OP_NORMAL: begin
                comb_res  = st.cfg[CFG_CASC_EN] ? (lut_norm & s_casc) : lut_norm;
                carry_res = 1'b0;
                d_sync    = st.cfg[CFG_PACKED] ? s_d4 : comb_res;
            end
            OP_ARITH: begin
                comb_res  = st.cfg[CFG_CASC_EN] ? (lut_data & s_casc) : lut_data;
                carry_res = lut_carry;
                d_sync    = comb_res;
            end
            OP_UPDOWN: begin
                comb_res  = lut_data;
                carry_res = lut_carry;
                d_sync    = s_d4 ? s_d2 : lut_data;
            end
            OP_CLRCNT: begin
                comb_res  = lut_data;
                carry_res = lut_carry;
                d_sync    = (s_d4 ? s_d2 : lut_data) & ~s_casc;
            end
            default: begin
                comb_res  = lut_norm;
                carry_res = 1'b0;
                d_sync    = comb_res;
            end
        endcase

        // Active-low clear and preset, idle high
        clr_n    = 1'b1;
        pre_n    = 1'b1;
        ctrl_clr = st.cfg[CFG_CLR_SRC] ? s_cb : s_ca;
        case (cp)
            CP_CLR: begin
                clr_n = ~ctrl_clr;
            end
            CP_PRE: begin
                pre_n = ~s_ca;
            end
            CP_CLR_PRE: begin
                pre_n = ~s_ca;
                clr_n = ~s_cb;
            end
            CP_LOAD_CLR: begin
                pre_n = ~(s_ca & s_d3);
                clr_n = ~(s_ca & ~s_d3) & ~s_cb;
            end
            CP_LOAD_PRE: begin
                pre_n = ~(s_ca & ~s_d3);
                clr_n = ~(s_ca & s_d3) & ~s_cb;
            end
            CP_LOAD: begin
                pre_n = ~(s_ca & s_d3);
                clr_n = ~(s_ca & ~s_d3);
            end
            default: begin
                clr_n = 1'b1;
                pre_n = 1'b1;
            end
        endcase

        // Register update: chip reset, then clear, preset, enabled capture
        chip_act = st.cfg[CFG_CHIPRST_EN] & ~s_chiprst_n;
        ce       = st.cfg[CFG_CE_EN] ? s_d1 : 1'b1;
        if (chip_act) begin
            next_st.cell_q = 1'b0;
        end else if (!clr_n) begin
            next_st.cell_q = 1'b0;
        end else if (!pre_n) begin
            next_st.cell_q = 1'b1;
        end else if (ce) begin
            next_st.cell_q = d_sync ^ inv;
        end

        // Registered cell outputs follow the new register value
        next_st.local_out   = st.cfg[CFG_LOCAL_REG] ? (next_st.cell_q ^ inv) : comb_res;
        next_st.global_out  = st.cfg[CFG_GLOBAL_REG] ? (next_st.cell_q ^ inv) : comb_res;
        next_st.carry_out   = carry_res;
        next_st.cascade_out = comb_res;
        next_st.lut_out     = comb_res;

        // Emulated bus: contention low, float high
        tri_oe  = st.tri_src[TRI_W-1:TRI_SRC];
        tri_dat = st.tri_src[TRI_SRC-1:0];
        if (tri_oe == '0) begin
            next_st.tri_out = 1'b1;
        end else if ($countones(tri_oe) > 1) begin
            next_st.tri_out = 1'b0;
        end else begin
            next_st.tri_out = |(tri_oe & tri_dat);
        end

        // Status word
        stat_word              = '0;
        stat_word[STAT_Q]      = q_obs;
        stat_word[STAT_LUT]    = st.lut_out;
        stat_word[STAT_CARRY]  = st.carry_out;
        stat_word[STAT_CASC]   = st.cascade_out;
        stat_word[STAT_TRI]    = st.tri_out;
        stat_word[STAT_REJECT] = st.cfg_reject;

        // Configuration write check
        wcfg     = pwdata[CFG_W-1:0];
        wcfg_bad = (wcfg[CFG_PACKED] & wcfg[CFG_CASC_EN]) |
                   (wcfg[CFG_CP_LSB +: CP_W] > CP_LAST);

        // APB slave: answer prepared in setup, taken in access
        setup_ph  = psel & ~penable;
        access_ph = psel & penable & st.pready;
        if (setup_ph) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = 1'b0;
            next_st.prdata  = '0;
            if (paddr == ADDR_CFG) begin
                next_st.prdata = {{(32-CFG_W){1'b0}}, st.cfg};
                if (pwrite && wcfg_bad) begin
                    next_st.pslverr    = 1'b1;
                    next_st.cfg_reject = 1'b1;
                end
            end else if (paddr == ADDR_LUT) begin
                next_st.prdata = {{(32-LUT_W){1'b0}}, st.lut};
            end else if (paddr == ADDR_STAT) begin
                next_st.prdata = stat_word;
            end else if (paddr == ADDR_TRI) begin
                next_st.prdata = {{(32-TRI_W){1'b0}}, st.tri_src};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end else if (access_ph) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata  = '0;
            if (pwrite && !st.pslverr) begin
                if (paddr == ADDR_CFG) begin
                    next_st.cfg        = wcfg;
                    next_st.cfg_reject = 1'b0;
                end else if (paddr == ADDR_LUT) begin
                    next_st.lut = pwdata[LUT_W-1:0];
                end else if (paddr == ADDR_TRI) begin
                    next_st.tri_src = pwdata[TRI_W-1:0];
                end
            end
        end else begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign prdata      = st.prdata;
    assign pready      = st.pready;
    assign pslverr     = st.pslverr;
    assign local_out   = st.local_out;
    assign global_out  = st.global_out;
    assign carry_out   = st.carry_out;
    assign cascade_out = st.cascade_out;
    assign tri_bus_out = st.tri_out;

    // Checks on the cell behaviour
    a_sync_ctrl_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##2 (s_ca == $past(cluster_ctrl_a, 2)))
        else $error("cluster_ctrl_a synchroniser latency wrong");

    a_chip_reset_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        chip_act |=> (st.cell_q == 1'b0))
        else $error("chip reset did not clear the register");

    a_clear_mode_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cp == CP_CLR && ctrl_clr && !chip_act) |=> (!st.cfg[CFG_LOCAL_REG] || !local_out)
            && (st.cell_q == 1'b0))
        else $error("asynchronous clear not applied");

    a_load_copy_d3: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((cp == CP_LOAD || cp == CP_LOAD_CLR) && s_ca && !s_cb && !chip_act)
        |=> (st.cell_q == $past(s_d3)))
        else $error("asynchronous load did not copy data_in_3");

    a_inv_load_pre: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cp == CP_LOAD_PRE && s_cb && !chip_act && $stable(st.cfg)) |=> (q_obs == 1'b1))
        else $error("load-with-preset did not set observed value");

    a_preset_and_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cp == CP_CLR_PRE && s_ca && !s_cb && !chip_act) |=> (st.cell_q == 1'b1))
        else $error("clear-and-preset mode did not preset");

    a_ce_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.cfg[CFG_CE_EN] && !s_d1 && clr_n && pre_n && !chip_act) |=> $stable(st.cell_q))
        else $error("register changed while clock enable low");

    a_clrcnt_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (op == OP_CLRCNT && !inv && s_casc && ce && clr_n && pre_n && !chip_act)
        |=> (st.cell_q == 1'b0))
        else $error("synchronous clear ignored in clearable counter");

    a_no_packed_casc: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(st.cfg[CFG_PACKED] && st.cfg[CFG_CASC_EN]))
        else $error("packed register combined with cascade");

    a_reject_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && pwrite && paddr == ADDR_CFG && wcfg_bad)
        |=> pslverr ##1 $stable(st.cfg))
        else $error("bad configuration write not refused");

    a_tri_float_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.tri_src[TRI_W-1:TRI_SRC] == '0) |=> tri_bus_out)
        else $error("floating emulated bus not high");

    a_tri_contend_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($countones(st.tri_src[TRI_W-1:TRI_SRC]) > 1) |=> !tri_bus_out)
        else $error("contending emulated bus not low");

    a_apb_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_ph |=> pready)
        else $error("APB answer not ready in access phase");

endmodule : lcm_logic_cell

// *** logic/lcm_pkg.sv ***
// Package: register map, field layout, reset values and modes of the logic cell
package lcm_pkg;

    // Register byte addresses on the APB
    localparam logic [11:0] ADDR_CFG  = 12'h000;
    localparam logic [11:0] ADDR_LUT  = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [11:0] ADDR_TRI  = 12'h00C;

    // Configuration word layout
    localparam int CFG_W          = 13;
    localparam int OP_W           = 2;
    localparam int CP_W           = 3;
    localparam int CFG_OP_LSB     = 0;
    localparam int CFG_CP_LSB     = 2;
    localparam int CFG_PACKED     = 5;
    localparam int CFG_CASC_EN    = 6;
    localparam int CFG_CARRY_SEL  = 7;
    localparam int CFG_LOCAL_REG  = 8;
    localparam int CFG_GLOBAL_REG = 9;
    localparam int CFG_CE_EN      = 10;
    localparam int CFG_CLR_SRC    = 11;
    localparam int CFG_CHIPRST_EN = 12;
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h0000;
    localparam logic [CP_W-1:0]  CP_LAST   = 3'h5;

    // Truth table word: low half data function, high half carry function
    localparam int LUT_W = 16;
    localparam logic [LUT_W-1:0] LUT_RESET = 16'h0000;

    // Status word layout
    localparam int STAT_Q      = 0;
    localparam int STAT_LUT    = 1;
    localparam int STAT_CARRY  = 2;
    localparam int STAT_CASC   = 3;
    localparam int STAT_TRI    = 4;
    localparam int STAT_REJECT = 5;

    // Pin synchroniser bit positions
    localparam int PIN_D1      = 0;
    localparam int PIN_D2      = 1;
    localparam int PIN_D3      = 2;
    localparam int PIN_D4      = 3;
    localparam int PIN_CIN     = 4;
    localparam int PIN_CASC    = 5;
    localparam int PIN_CA      = 6;
    localparam int PIN_CB      = 7;
    localparam int PIN_CHIPRST = 8;
    localparam int PIN_W       = 9;
    localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 9'h100;

    // Operating modes of the cell
    typedef enum logic [OP_W-1:0] {OP_NORMAL, OP_ARITH, OP_UPDOWN, OP_CLRCNT} lcm_op_t;

    // Clear and preset configurations
    typedef enum logic [CP_W-1:0] {
        CP_CLR, CP_PRE, CP_CLR_PRE, CP_LOAD_CLR, CP_LOAD_PRE, CP_LOAD
    } lcm_cp_t;

endpackage : lcm_pkg

// *** tb/lcm_nbr_model.sv ***
// Neighbouring cells and cluster routing that drive the cell pins
module lcm_nbr_model
    import lcm_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [PIN_W-1:0] pins,
    output logic                  data_in_1,
    output logic                  data_in_2,
    output logic                  data_in_3,
    output logic                  data_in_4,
    output logic                  carry_in,
    output logic                  cascade_in,
    output logic                  cluster_ctrl_a,
    output logic                  cluster_ctrl_b,
    output logic                  chip_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PIN_W-1:0] drv;

    // Levels launched just after each rising edge, idle with chip reset off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv <= PIN_SYNC_RESET;
        end else begin
            drv <= pins;
        end
    end

    // Fan the launched levels out to the pins
    assign {chip_reset_n, cluster_ctrl_b, cluster_ctrl_a, cascade_in, carry_in,
            data_in_4, data_in_3, data_in_2, data_in_1} = drv;
endmodule : lcm_nbr_model

// *** tb/tb.sv ***
// Self-checking bench of the logic cell
module tb
    import lcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [8:0]  pins, p;
    logic        d1, d2, d3, d4, cin, casc, ca, cb, crst_n, s, e, q;
    logic        local_out, global_out, carry_out, cascade_out, tri_bus_out;
    logic [15:0] lut;
    logic [7:0]  v;
    logic [2:0]  cp;
    int          n_errors, num_checks, seed, i, k, t;
    int          cyc = 0;

    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    lcm_nbr_model u_lcm_nbr_model (.pclk(pclk), .presetn(presetn), .pins(pins),
        .data_in_1(d1), .data_in_2(d2), .data_in_3(d3), .data_in_4(d4),
        .carry_in(cin), .cascade_in(casc), .cluster_ctrl_a(ca),
        .cluster_ctrl_b(cb), .chip_reset_n(crst_n));

    lcm_logic_cell #(.TRI_SRC(4)) u_lcm_logic_cell (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_in_1(d1), .data_in_2(d2), .data_in_3(d3), .data_in_4(d4),
        .carry_in(cin), .cascade_in(casc), .cluster_ctrl_a(ca),
        .cluster_ctrl_b(cb), .chip_reset_n(crst_n), .local_out(local_out),
        .global_out(global_out), .carry_out(carry_out),
        .cascade_out(cascade_out), .tri_bus_out(tri_bus_out));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // APB transfer: setup, access until pready, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        er = pslverr;
        chk("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Present pin levels and let them pass the launch and sync stages
    task automatic setp(input logic [8:0] x);
        pins <= x;
        repeat (6) @(posedge pclk);
    endtask : setp

    // Resolved emulated bus: none enabled high, several low
    function automatic logic tri_exp(input logic [7:0] x);
        int c;
        logic o;
        c = 0;
        o = 1'b1;
        for (int j = 0; j < 4; j++) begin
            if (x[4+j]) begin
                c++;
                o = x[j];
            end
        end
        return (c > 1) ? 1'b0 : o;
    endfunction : tri_exp

    // Observed register after async controls over a pending capture nb
    function automatic logic aexp(input logic [2:0] m, input logic [31:0] x);
        logic a, b, dd;
        a = x[1];
        b = x[2];
        dd = x[3] | (m == 3'h1) | (m == 3'h2);
        if (x[4] && !(x[5] | x[6])) return (m == 3'h4);
        case (m)
            3'h0: if (x[0] ? b : a) return 1'b0;
            3'h1: if (a) return 1'b1;
            3'h2: if (b) return 1'b0; else if (a) return 1'b1;
            3'h3: if (b) return 1'b0; else if (a) return dd;
            3'h4: if (b) return 1'b1; else if (a) return dd;
            default: if (a) return dd;
        endcase
        return x[7];
    endfunction : aexp

    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        seed = 45708;
        n_errors = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pins = PIN_SYNC_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped place and refused configurations
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("cfg", 32'(CFG_RESET), rd);
        apb(1'b0, ADDR_LUT, 32'h0);
        chk("lut", 32'(LUT_RESET), rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        apb(1'b1, ADDR_CFG, 32'h60);
        chk("pack_casc", 32'h1, 32'(er));
        apb(1'b1, ADDR_CFG, 32'h18);
        chk("cp_range", 32'h1, 32'(er));
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("refused", 32'h1, 32'(rd[STAT_REJECT]));
        apb(1'b0, ADDR_CFG, 32'h0);
        chk("cfg_kept", 32'h0, rd);
        // Counter modes, one enabled edge per step
        q = 1'b0;
        for (k = 2; k < 4; k++) begin
            lut = 16'($random(seed));
            // Enable gating first so the new table cannot disturb the held bit
            apb(1'b1, ADDR_CFG, 32'h600 | k);
            apb(1'b1, ADDR_LUT, {16'h0, lut});
            for (i = 0; i < 16; i++) begin
                p = 9'h100 | (9'($random(seed)) & 9'h03E);
                setp(p);
                chk("hold", 32'(q), 32'(global_out));
                pins <= p | 9'h001;
                @(posedge pclk);
                setp(p);
                e = p[3] ? p[1] : lut[{1'b0, p[4], p[2], q}];
                q = e & !(k == 3 && p[5]);
                chk("count", 32'(q), 32'(global_out));
                chk("cnt_carry", 32'(lut[{1'b1, p[4], p[2], q}]), 32'(carry_out));
            end
        end
        // Lookup function, cascade and carry in normal and arithmetic modes
        for (i = 0; i < 32; i++) begin
            r = $random(seed);
            lut = r[15:0];
            s = r[16];
            k = i % 2;
            p = 9'h100 | 9'(r[31:23]);
            apb(1'b1, ADDR_LUT, {16'h0, lut});
            apb(1'b1, ADDR_CFG, (32'(r[17]) << 6) | (32'(s) << 7) | k);
            setp(p);
            if (k == 0) begin
                e = lut[{p[3], (s ? p[4] : p[2]), p[1], p[0]}];
            end else begin
                e = lut[{1'b0, p[4], p[1], p[0]}];
                chk("carry", 32'(lut[{1'b1, p[4], p[1], p[0]}]), 32'(carry_out));
            end
            // Cascade-in gates the function only while the chain is enabled
            e = e & (p[5] | !r[17]);
            chk("casc", 32'(e), 32'(cascade_out));
            chk("func", 32'(e), 32'(local_out));
        end
        // Emulated bus with corner enables first
        for (i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'h0A : (i == 1) ? 8'hF5 : 8'($random(seed));
            apb(1'b1, ADDR_TRI, {24'h0, v});
            repeat (3) @(posedge pclk);
            chk("tri", 32'(tri_exp(v)), 32'(tri_bus_out));
        end
        // Async controls and chip reset against a pending packed capture
        for (i = 0; i < 48; i++) begin
            r = $random(seed);
            cp = 3'(i % 6);
            apb(1'b1, ADDR_CFG, {19'h0, r[4], r[0], 6'h31, cp, 2'h0});
            setp({5'h10, ~r[7], 3'h1});
            setp({5'h10, ~r[7], 3'h0});
            setp({r[5] | r[6], r[2], r[1], 2'h0, r[7],
                  r[3] | (cp == 3'h1) | (cp == 3'h2), 2'h1});
            chk("async", 32'(aexp(cp, r)), 32'(global_out));
            setp({5'h10, r[7], 3'h0});
            chk("async_hold", 32'(aexp(cp, r)), 32'(global_out));
        end
        end_of_test();
    end
endmodule : tb
